// [design/mode_switch_device.sv]
// Purpose: device end: two-wire slave taking pointer, config and commands
// Assumes: scl and sda are asynchronous pins, synchronised to mclk
// Notes:   conversion engine and nonvolatile store are outside this block
`timescale 1ns/10ps
`default_nettype none
module mode_switch_device #(
    parameter logic [6:0] DEV_ADDR = mode_switch_pkg::DEV_ADDR_DEFAULT,
    parameter int         COPY_CYCLES = mode_switch_pkg::COPY_CYCLES
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    two_wire_if.device        link,
    output logic              single_conversion_select,
    output logic              converting,
    output logic              start_conv_pulse,
    output logic              copy_pulse,
    output logic [7:0]        nv_config,
    output logic              nonvolatile_busy_flag
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RX   = 5'h02,
        S_ACK  = 5'h04,
        S_ACKE = 5'h08,
        S_SKIP = 5'h10
    } dstate_t;

    logic [1:0] scl_s_reg, sda_s_reg, scl_s_next, sda_s_next;
    logic       scl_d_reg, sda_d_reg, scl_d_next, sda_d_next;
    dstate_t    st_reg, st_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] bit_reg, bit_next;
    logic [1:0] idx_reg, idx_next;
    logic       ptr_ok_reg, ptr_ok_next;
    logic       oe_reg, oe_next;
    logic [7:0] shadow_reg, shadow_next, nv_reg, nv_next;
    logic       conv_reg, conv_next, st_p_reg, st_p_next, cp_p_reg, cp_p_next;
    logic [31:0] busy_cnt_reg, busy_cnt_next;

    logic scl_i, sda_i, scl_rise, scl_fall, start_c, stop_c;
    assign scl_i    = scl_s_reg[1];
    assign sda_i    = sda_s_reg[1];
    assign scl_rise = scl_i & ~scl_d_reg;
    assign scl_fall = ~scl_i & scl_d_reg;
    assign start_c  = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
    assign stop_c   = scl_i & scl_d_reg & ~sda_d_reg & sda_i;

    assign link.sda_oe_d               = oe_reg;
    assign single_conversion_select    = shadow_reg[mode_switch_pkg::MODE_BIT_POS];
    assign converting                  = conv_reg;
    assign start_conv_pulse            = st_p_reg;
    assign copy_pulse                  = cp_p_reg;
    assign nv_config                   = nv_reg;
    assign nonvolatile_busy_flag       = (busy_cnt_reg != 32'h0);

    // two flops before any logic reads the pins; the edge registers read only the second
    always_comb begin
        scl_s_next = {scl_s_reg[0], link.scl};
        sda_s_next = {sda_s_reg[0], link.sda};
        scl_d_next = scl_i;
        sda_d_next = sda_i;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // idle level of both lines, so no false edge follows reset
            scl_s_reg <= 2'h3;
            sda_s_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_s_reg <= scl_s_next;
            sda_s_reg <= sda_s_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // a new copy reloads the count even while one still runs, so the load wins
    always_comb begin
        if (cp_p_next) begin
            busy_cnt_next = 32'(COPY_CYCLES);
        end else if (busy_cnt_reg != 32'h0) begin
            busy_cnt_next = busy_cnt_reg - 32'h1;
        end else begin
            busy_cnt_next = busy_cnt_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    always_comb begin
        st_next     = st_reg;
        sh_next     = sh_reg;
        bit_next    = bit_reg;
        idx_next    = idx_reg;
        ptr_ok_next = ptr_ok_reg;
        oe_next     = oe_reg;
        shadow_next = shadow_reg;
        nv_next     = nv_reg;
        conv_next   = conv_reg;
        st_p_next   = 1'b0;
        cp_p_next   = 1'b0;
        if (start_c) begin
            // a repeated start restarts the address phase
            st_next  = S_RX;
            bit_next = 4'h0;
            idx_next = 2'h0;
            oe_next  = 1'b0;
        end else if (stop_c) begin
            st_next = S_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                S_RX: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], sda_i};
                        bit_next = bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        bit_next = 4'h0;
                        if (idx_reg == 2'h0) begin
                            if (sh_reg == {DEV_ADDR, 1'b0}) begin
                                oe_next = 1'b1;
                                st_next = S_ACK;
                            end else begin
                                st_next = S_SKIP;
                            end
                        end else begin
                            oe_next = 1'b1;
                            st_next = S_ACK;
                            if (idx_reg == 2'h1) begin
                                if (sh_reg == mode_switch_pkg::CMD_START_CONV) begin
                                    conv_next = 1'b1;
                                    st_p_next = 1'b1;
                                end else if (sh_reg == mode_switch_pkg::CMD_COPY_NV) begin
                                    nv_next       = shadow_reg;
                                    cp_p_next     = 1'b1;
                                end
                                ptr_ok_next = (sh_reg == mode_switch_pkg::PTR_CFG_MSB);
                            end else if (ptr_ok_reg) begin
                                shadow_next = sh_reg;
                                ptr_ok_next = 1'b0;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_rise) begin
                        st_next = S_ACKE;
                    end
                end
                S_ACKE: begin
                    if (scl_fall) begin
                        oe_next  = 1'b0;
                        st_next  = S_RX;
                        idx_next = (idx_reg == 2'h3) ? idx_reg : idx_reg + 2'h1;
                    end
                end
                default: begin
                    st_next = st_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg     <= S_IDLE;
            sh_reg     <= 8'h00;
            bit_reg    <= 4'h0;
            idx_reg    <= 2'h0;
            ptr_ok_reg <= 1'b0;
            oe_reg     <= 1'b0;
            shadow_reg <= mode_switch_pkg::CFG_RESET;
            nv_reg     <= mode_switch_pkg::CFG_RESET;
            conv_reg   <= 1'b0;
            st_p_reg   <= 1'b0;
            cp_p_reg   <= 1'b0;
        end else begin
            st_reg     <= st_next;
            sh_reg     <= sh_next;
            bit_reg    <= bit_next;
            idx_reg    <= idx_next;
            ptr_ok_reg <= ptr_ok_next;
            oe_reg     <= oe_next;
            shadow_reg <= shadow_next;
            nv_reg     <= nv_next;
            conv_reg   <= conv_next;
            st_p_reg   <= st_p_next;
            cp_p_reg   <= cp_p_next;
        end
    end
endmodule
`default_nettype wire

// [design/mode_switch_master.sv]
// Purpose: master end: runs the switch to continuous conversion sequence
// Assumes: go is a one-cycle pulse on mclk
// Notes:   waits out the copy time after the copy command before idling
`timescale 1ns/10ps
`default_nettype none
module mode_switch_master #(
    parameter logic [6:0] DEV_ADDR = mode_switch_pkg::DEV_ADDR_DEFAULT,
    parameter int         QUARTER  = mode_switch_pkg::QUARTER_CYCLES,
    parameter int         COPY_CYCLES = mode_switch_pkg::COPY_CYCLES
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  go,
    input  wire logic  [7:0] cfg_upper,
    two_wire_if.master link,
    output logic       busy,
    output logic       done,
    output logic       nack_err
);
    typedef enum logic [5:0] {
        M_IDLE  = 6'h01,
        M_START = 6'h02,
        M_BIT   = 6'h04,
        M_ACK   = 6'h08,
        M_STOP  = 6'h10,
        M_WAIT  = 6'h20
    } mstate_t;

    mstate_t     st_reg, st_next;
    logic [1:0]  ph_reg, ph_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [2:0]  byte_reg, byte_next;
    logic [2:0]  bit_reg, bit_next;
    logic        scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic        done_reg, done_next, err_reg, err_next;
    logic [1:0]  sda_s_reg;
    logic [7:0]  cur_byte;
    logic        tick;

    // byte plan: addr, ptr, cfg | addr, start | addr, copy
    always_comb begin
        case (byte_reg)
            3'h1: cur_byte = mode_switch_pkg::PTR_CFG_MSB;
            3'h2: cur_byte = {cfg_upper[7:1], 1'b0};
            3'h4: cur_byte = mode_switch_pkg::CMD_START_CONV;
            3'h6: cur_byte = mode_switch_pkg::CMD_COPY_NV;
            default: cur_byte = {DEV_ADDR, 1'b0};
        endcase
    end

    assign tick          = (cnt_reg == 32'h0);
    assign link.scl_oe_m = scl_oe_reg;
    assign link.sda_oe_m = sda_oe_reg;
    assign busy          = (st_reg != M_IDLE);
    assign done          = done_reg;
    assign nack_err      = err_reg;

    always_comb begin
        st_next     = st_reg;
        ph_next     = ph_reg;
        byte_next   = byte_reg;
        bit_next    = bit_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        done_next   = 1'b0;
        err_next    = err_reg;
        cnt_next    = tick ? 32'(QUARTER - 1) : cnt_reg - 32'h1;
        case (st_reg)
            M_IDLE: begin
                cnt_next = 32'h0;
                if (go) begin
                    st_next   = M_START;
                    ph_next   = 2'h0;
                    byte_next = 3'h0;
                    err_next  = 1'b0;
                end
            end
            M_START: begin
                // repeated start: release sda, raise scl, then pull sda low
                if (tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_oe_next = 1'b0;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b1;
                        default: begin
                            scl_oe_next = 1'b1;
                            st_next     = M_BIT;
                            bit_next    = 3'h7;
                        end
                    endcase
                end
            end
            M_BIT, M_ACK: begin
                if (tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_oe_next = (st_reg == M_BIT) ? ~cur_byte[bit_reg] : 1'b0;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: begin
                            if (st_reg == M_ACK && sda_s_reg[1]) begin
                                err_next = 1'b1;
                            end
                        end
                        default: begin
                            scl_oe_next = 1'b1;
                            if (st_reg == M_BIT) begin
                                bit_next = bit_reg - 3'h1;
                                if (bit_reg == 3'h0) begin
                                    st_next = M_ACK;
                                end
                            end else begin
                                byte_next = byte_reg + 3'h1;
                                bit_next  = 3'h7;
                                if (err_reg || byte_reg == 3'h6) begin
                                    st_next = M_STOP;
                                end else if (byte_reg == 3'h2 || byte_reg == 3'h4) begin
                                    st_next = M_START;
                                end else begin
                                    st_next = M_BIT;
                                end
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    ph_next = ph_reg + 2'h1;
                    case (ph_reg)
                        2'h0: sda_oe_next = 1'b1;
                        2'h1: scl_oe_next = 1'b0;
                        2'h2: sda_oe_next = 1'b0;
                        default: begin
                            st_next  = M_WAIT;
                            cnt_next = 32'(COPY_CYCLES);
                        end
                    endcase
                end
            end
            default: begin
                // copy time must elapse before anything conflicting
                if (tick) begin
                    st_next   = M_IDLE;
                    done_next = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg     <= M_IDLE;
            ph_reg     <= 2'h0;
            cnt_reg    <= 32'h0;
            byte_reg   <= 3'h0;
            bit_reg    <= 3'h7;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            done_reg   <= 1'b0;
            err_reg    <= 1'b0;
            sda_s_reg  <= 2'h3;
        end else begin
            st_reg     <= st_next;
            ph_reg     <= ph_next;
            cnt_reg    <= cnt_next;
            byte_reg   <= byte_next;
            bit_reg    <= bit_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
            done_reg   <= done_next;
            err_reg    <= err_next;
            sda_s_reg  <= {sda_s_reg[0], link.sda};
        end
    end
endmodule
`default_nettype wire

// [design/mode_switch_pkg.sv]
// Purpose: shared constants for the two-wire conversion mode switch ends
// Assumes: 200 MHz mclk, master-generated serial clock from a divider
// Notes:   device address and divider are plain defaults
package mode_switch_pkg;
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h48;
    localparam logic [7:0]  PTR_CFG_MSB      = 8'hAC;
    localparam logic [7:0]  CMD_START_CONV   = 8'h51;
    localparam logic [7:0]  CMD_COPY_NV      = 8'h48;
    localparam int          MODE_BIT_POS     = 0;
    localparam logic [7:0]  CFG_RESET        = 8'h01;
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          COPY_TIME_MS     = 10;
    localparam int          COPY_CYCLES      = COPY_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          QUARTER_CYCLES   = 125;
endpackage

// [design/two_wire_if.sv]
// Purpose: open-drain two-wire link between master and device ends
// Assumes: pull-ups modelled by resolving the enables
// Notes:   a line reads low while either party drives it
`timescale 1ns/10ps
`default_nettype none
interface two_wire_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_d;
    logic scl;
    logic sda;
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_d);
    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport device (output sda_oe_d, input scl, input sda);
endinterface
`default_nettype wire

// [sim/mode_switch_sva.sv]
// Purpose: checker for the two-wire mode switch link and its device end
// Assumes: instantiated beside the address-matched link in the bench
// Notes:   the foreign-address pair is judged by the bench alone
`timescale 1ns/10ps
`default_nettype none
module mode_switch_sva (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       sda_oe_d,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       nack_err,
    input wire logic       converting,
    input wire logic       start_conv_pulse,
    input wire logic       copy_pulse,
    input wire logic       single_conversion_select,
    input wire logic       nonvolatile_busy_flag,
    input wire logic [7:0] nv_config
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_idle_lines: assert property (!busy |-> scl && sda)
        else $error("lines not released while idle");
    chk_ack_setup: assert property ($rose(sda_oe_d) |-> !scl)
        else $error("ack driven while clock high");
    chk_ack_release: assert property ($fell(sda_oe_d) |-> !scl)
        else $error("ack released while clock high");
    chk_ack_hold: assert property ($rose(sda_oe_d) |-> sda_oe_d [*8])
        else $error("ack dropped early");
    chk_no_nack: assert property (!nack_err)
        else $error("matched device left a byte unacknowledged");
    chk_conv_start: assert property (start_conv_pulse |=> converting)
        else $error("start command did not start conversions");
    chk_mode_cleared: assert property (copy_pulse |-> !single_conversion_select)
        else $error("mode bit still set at copy");
    chk_copy_order: assert property (copy_pulse |-> converting)
        else $error("copy seen before start command");
    chk_copy_busy: assert property (copy_pulse |=> nonvolatile_busy_flag)
        else $error("copy did not raise busy flag");
    chk_nv_copy: assert property (copy_pulse |=> nv_config[0] == $past(single_conversion_select))
        else $error("nonvolatile copy does not hold the shadow");
    chk_done_idle: assert property (done |-> !nonvolatile_busy_flag)
        else $error("sequence ended while copy still running");

    cover property ($rose(sda_oe_d));
    cover property (start_conv_pulse);
    cover property (copy_pulse);
    cover property (done);
endmodule
`default_nettype wire

// [sim/test_conversion_mode_switch_sequencer.sv]
// Purpose: bench joining master and device ends over the two-wire link
// Assumes: shortened quarter bit and copy time
// Notes:   a second pair with a foreign device address exercises refusal
`timescale 1ns/10ps
`default_nettype none
module test_conversion_mode_switch_sequencer;
    logic        mclk, rst_n, go, go2, busy, done, nack_err, busy2, nack_err2;
    logic        single_conversion_select, converting, start_conv_pulse, copy_pulse;
    logic        nonvolatile_busy_flag, converting2;
    logic [7:0]  cfg_upper, nv_config, nv_config2, shift_v;
    logic [7:0]  got[$];
    logic        acks[$];
    int          num_errors, samples_checked, n_start, n_stop, n_sc, n_cp, bitn, seed;
    // shortened bit and copy times keep the run short
    localparam int         SIM_QUARTER  = 4;
    localparam int         SIM_COPY     = 50;
    localparam logic [6:0] FOREIGN_ADDR = 7'h49;

    two_wire_if lk();
    two_wire_if lk2();
    mode_switch_master #(.QUARTER(SIM_QUARTER), .COPY_CYCLES(SIM_COPY)) mode_switch_master_i (
        .mclk(mclk), .rst_n(rst_n), .go(go), .cfg_upper(cfg_upper), .link(lk),
        .busy(busy), .done(done), .nack_err(nack_err));
    mode_switch_device #(.COPY_CYCLES(SIM_COPY)) mode_switch_device_i (
        .mclk(mclk), .rst_n(rst_n), .link(lk),
        .single_conversion_select(single_conversion_select), .converting(converting),
        .start_conv_pulse(start_conv_pulse), .copy_pulse(copy_pulse),
        .nv_config(nv_config), .nonvolatile_busy_flag(nonvolatile_busy_flag));
    // device answers a different address, so the master must see a refusal
    mode_switch_master #(.QUARTER(SIM_QUARTER), .COPY_CYCLES(SIM_COPY)) mode_switch_master_i2 (
        .mclk(mclk), .rst_n(rst_n), .go(go2), .cfg_upper(cfg_upper), .link(lk2),
        .busy(busy2), .done(), .nack_err(nack_err2));
    mode_switch_device #(.DEV_ADDR(FOREIGN_ADDR), .COPY_CYCLES(SIM_COPY)) mode_switch_device_i2 (
        .mclk(mclk), .rst_n(rst_n), .link(lk2), .single_conversion_select(),
        .converting(converting2), .start_conv_pulse(), .copy_pulse(),
        .nv_config(nv_config2), .nonvolatile_busy_flag());
    mode_switch_sva mode_switch_sva_i (
        .mclk(mclk), .rst_n(rst_n), .scl(lk.scl), .sda(lk.sda), .sda_oe_d(lk.sda_oe_d),
        .busy(busy), .done(done), .nack_err(nack_err), .converting(converting),
        .start_conv_pulse(start_conv_pulse), .copy_pulse(copy_pulse),
        .single_conversion_select(single_conversion_select),
        .nonvolatile_busy_flag(nonvolatile_busy_flag), .nv_config(nv_config));

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    // wire monitor: framing and bytes decoded from the resolved lines
    always @(negedge lk.sda) if (lk.scl === 1'b1) begin
        n_start++;
        bitn = 0;
    end
    always @(posedge lk.sda) if (lk.scl === 1'b1) n_stop++;
    always @(posedge lk.scl) begin
        if (bitn < 8) shift_v = {shift_v[6:0], lk.sda};
        else begin
            got.push_back(shift_v);
            acks.push_back(lk.sda);
        end
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end
    // pulses are looked at mid-cycle, where they stand settled
    always @(negedge mclk) begin
        if (start_conv_pulse === 1'b1) n_sc++;
        if (copy_pulse === 1'b1) n_cp++;
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic checkn(input string what, input int exp, input int seen);
        samples_checked++;
        if (seen != exp) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_byte(input int i, input logic [7:0] cu);
        case (i)
            1: return mode_switch_pkg::PTR_CFG_MSB;
            2: return {cu[7:1], 1'b0};
            4: return mode_switch_pkg::CMD_START_CONV;
            6: return mode_switch_pkg::CMD_COPY_NV;
            default: return {mode_switch_pkg::DEV_ADDR_DEFAULT, 1'b0};
        endcase
    endfunction

    task automatic pulse_go(input logic [7:0] cu);
        cfg_upper = cu;
        go = 1'b1;
        @(negedge mclk);
        go = 1'b0;
    endtask

    // extra asks for a second go while busy, which must be ignored
    task automatic run_seq(input logic [7:0] cu, input bit extra);
        int k;
        got.delete();
        acks.delete();
        n_start = 0; n_stop = 0; n_sc = 0; n_cp = 0;
        pulse_go(cu);
        if (extra) begin
            repeat (40) @(negedge mclk);
            pulse_go(cu);
        end
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(negedge mclk);
            k++;
        end
        checkn("done in time", 1, int'(k < 3000));
        checkn("frames", 3, n_start);
        checkn("stops", 1, n_stop);
        checkn("bytes", 7, got.size());
        for (int i = 0; i < got.size() && i < 7; i++) begin
            check8("byte", exp_byte(i, cu), got[i]);
            check8("ack", 8'h00, {7'h00, acks[i]});
        end
        checkn("starts", 1, n_sc);
        checkn("copies", 1, n_cp);
        check8("mode", 8'h00, {7'h00, single_conversion_select});
        check8("nv", {cu[7:1], 1'b0}, nv_config);
        check8("conv", 8'h01, {7'h00, converting});
        check8("nvbusy", 8'h00, {7'h00, nonvolatile_busy_flag});
        check8("nack", 8'h00, {7'h00, nack_err});
        @(negedge mclk);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        finish_test;
    end

    initial begin
        int k;
        seed = 32'h7C4CDE98;
        rst_n = 1'b0; go = 1'b0; go2 = 1'b0; cfg_upper = 8'h00;
        repeat (6) @(negedge mclk);
        check8("rst mode", 8'h01, {7'h00, single_conversion_select});
        check8("rst nv", mode_switch_pkg::CFG_RESET, nv_config);
        check8("rst lines", 8'h03, {6'h00, lk.scl, lk.sda});
        rst_n = 1'b1;
        run_seq(8'h00, 1'b0);
        run_seq(8'hFF, 1'b1);
        repeat (8) run_seq(8'($random(seed)), 1'b0);
        go2 = 1'b1;
        @(negedge mclk);
        go2 = 1'b0;
        k = 0;
        while (busy2 !== 1'b0 && k < 3000) begin
            @(negedge mclk);
            k++;
        end
        checkn("foreign idle in time", 1, int'(k < 3000));
        check8("foreign nack", 8'h01, {7'h00, nack_err2});
        check8("foreign conv", 8'h00, {7'h00, converting2});
        check8("foreign nv", mode_switch_pkg::CFG_RESET, nv_config2);
        pulse_go(8'h3C);
        repeat (150) @(negedge mclk);
        rst_n = 1'b0;
        repeat (6) @(negedge mclk);
        check8("abort conv", 8'h00, {7'h00, converting});
        check8("abort lines", 8'h03, {6'h00, lk.scl, lk.sda});
        rst_n = 1'b1;
        run_seq(8'h5A, 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire
